// ==== rtl/srp_params.svh ====
// offsets, field positions, reset values and counts of the serial register port
`ifndef SRP_PARAMS_SVH
`define SRP_PARAMS_SVH

// ----------------------------------------------------------------
// frame shape
// ----------------------------------------------------------------
`define SRP_FRAME_BITS     5'h10
`define SRP_CMD_MSB        15
`define SRP_CMD_LSB        12
`define SRP_ADDR_MSB       11
`define SRP_ADDR_LSB       8
`define SRP_CHECK_TOP      4'h7

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SRP_VRS_KLINE_STATUS_ADDR  4'hb
`define SRP_SYS_FAULT_STATUS_ADDR  4'hd
`define SRP_MODEL_REV_ADDR         4'hf
`define SRP_SELFTEST_CTRL_ADDR     4'h0

// ----------------------------------------------------------------
// field positions and existing-bit masks
// ----------------------------------------------------------------
`define SRP_KLINE_OT_BIT       0
`define SRP_NEG_CLAMP_BIT      1
`define SRP_POS_CLAMP_BIT      2
`define SRP_PEAK_LSB           4
`define SRP_FRAME_ERR_BIT      3
`define SRP_SELFTEST_BIT       0
`define SRP_VRS_KLINE_MASK     8'hf7
`define SRP_SYS_FAULT_MASK     8'hff
`define SRP_STATUS_RESET       8'h00
`define SRP_RESP_RESET         16'h0000

`endif

// ==== rtl/srp_pkg.sv ====
// types shared by the serial register port modules
package srp_pkg;

	// command codes in the top nibble of a frame
	typedef enum logic [3:0] {
		CMD_CHECK    = 4'h0,
		CMD_RD_CFG   = 4'h1,
		CMD_WR_CFG   = 4'h2,
		CMD_RD_STAT  = 4'h3,
		CMD_WR_STAT  = 4'h4,
		CMD_RD_CTRL  = 4'h5,
		CMD_WR_CTRL  = 4'h6,
		CMD_CHECK_RS = 4'h7
	} srp_cmd_t;

	// frame tracking states, gray along idle -> frame -> exec
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_FRAME = 2'h1,
		ST_EXEC  = 2'h3
	} srp_state_t;

endpackage

// ==== rtl/srp_link_if.sv ====
// signals between the serial-clock shifter and the core-clock register logic
`timescale 1ns/1ps
`default_nettype none

interface srp_link_if;
	logic [15:0] rx_word;      // last word shifted in, stable while select is high
	logic [4:0]  pulse_count;  // rising serial clock edges in the frame, saturating
	logic [15:0] resp_word;    // word to shift out in the next frame
	logic        so_bit;       // current serial output bit

	// shifter side
	modport link (
		output rx_word,
		output pulse_count,
		output so_bit,
		input  resp_word
	);

	// register side
	modport core (
		input  rx_word,
		input  pulse_count,
		input  so_bit,
		output resp_word
	);
endinterface

`default_nettype wire

// ==== rtl/srp_shifter.sv ====
// serial-clock domain shifter: input shift register, pulse counter, output bit select
`timescale 1ns/1ps
`default_nettype none

module srp_shifter (
	// link pins
	input wire logic   sclk,
	input wire logic   chip_select_n,
	input wire logic   sdi_in,
	// toward the core
	srp_link_if.link   lnk
);

	logic [15:0] rx_reg;
	logic [4:0]  cnt_reg;
	logic [4:0]  hold_reg;
	logic [3:0]  idx_reg;

	// ----------------------------------------------------------------
	// input side
	// ----------------------------------------------------------------
	// capture on rising edges while selected, msb arrives first
	always_ff @(posedge sclk) begin
		if (!chip_select_n) begin
			rx_reg <= {rx_reg[14:0], sdi_in};
		end
	end

	// pulse counter, held clear while deselected so stray clocks are ignored
	always_ff @(posedge sclk or posedge chip_select_n) begin
		if (chip_select_n) begin
			cnt_reg <= 5'h00;
		end else if (cnt_reg != 5'h1f) begin
			cnt_reg <= cnt_reg + 5'h01;
		end
	end

	// the counter clears as select rises, so the frame's count is kept here
	// at that same edge; it stays put until the next frame ends, long after
	// the core has executed. limitation: the counter's clear shares this edge
	always_ff @(posedge chip_select_n) begin
		hold_reg <= cnt_reg;
	end

	// ----------------------------------------------------------------
	// output side
	// ----------------------------------------------------------------
	// bit index moves on falling edges; clear at deselect so bit 15 is
	// on the pin as soon as select falls, before any clock edge
	always_ff @(negedge sclk or posedge chip_select_n) begin
		if (chip_select_n) begin
			idx_reg <= 4'h0;
		end else if (idx_reg != 4'hf) begin
			idx_reg <= idx_reg + 4'h1;
		end
	end

	assign lnk.rx_word     = rx_reg;
	assign lnk.pulse_count = hold_reg;
	assign lnk.so_bit      = lnk.resp_word[4'hf - idx_reg];

endmodule

`default_nettype wire

// ==== rtl/srp_port.sv ====
// serial register port: frame checking, command execution and status registers
`timescale 1ns/1ps
`default_nettype none

`include "srp_params.svh"

// What this block does
// - sample serial input on rising serial clock while select is low
// - serial output changes on falling serial clock edges
// - deselected: ignore clock and input, output not driven
// - accept only frames of exactly 16 pulses, else discard and flag error
// - invalid command or address in a 16-bit frame flags error
// - select falling enables output and presents pending response
// - select rising releases output and executes received word
// - both words shift most significant bit first
// - faulted drivers report 1, healthy drivers report 0
// - response shifted out answers the previous frame
// - check frame echoes low 12 bits, inverts bits 12-14, bit 15 zero
// - without self-test, host writes only clear status bits
// - with self-test, host writes any existing status bit
// - self-test freezes fault updates of status registers
// - non-existent bits stay zero under all writes
// - device sets and clears non-fault status bits itself outside self-test
// - status 11 bit 0 is k-line overtemperature, resets to 0
// - status 15 read-only except self-test: model code 7-5, revision 4-0
// - frame: 4-bit command, 4-bit address, 8 data bits
// - frame error flag is status 13 bit 3
module srp_port #(
	parameter logic [2:0] MODEL_CODE = 3'h5,  // arbitrary value
	parameter logic [4:0] REVISION   = 5'h01  // arbitrary value
) (
	// core clock and reset
	input wire logic  core_clk,
	input wire logic  reset,
	// serial link
	input wire logic  sclk,
	input wire logic  chip_select_n,
	input wire logic  sdi_in,
	output logic      sdo_out,
	output logic      sdo_oe,
	// fault and level inputs from the analog blocks
	input wire logic  kline_overtemp_in,
	input wire logic  vrs_pos_clamp_in,
	input wire logic  vrs_neg_clamp_in,
	input wire logic [3:0] vrs_peak_in,
	// state seen by the rest of the chip
	output logic      selftest_write_enable,
	output logic      frame_error_flag
);

	srp_link_if lnk ();

	srp_shifter u_shifter (
		.sclk          (sclk),
		.chip_select_n (chip_select_n),
		.sdi_in        (sdi_in),
		.lnk           (lnk)
	);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [7:0] pin_raw;
	logic [7:0] pin_meta;
	logic [7:0] pin_sync;

	assign pin_raw = {vrs_peak_in, kline_overtemp_in, vrs_pos_clamp_in,
		vrs_neg_clamp_in, chip_select_n};

	// idle levels: select high, fault pins low, so no false sticky set after reset
	localparam logic [7:0] PIN_IDLE = 8'h01;

	// two flops per asynchronous pin; only the second stage is read
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_sync
			always_ff @(posedge core_clk) begin
				if (reset) begin
					pin_meta[gi] <= PIN_IDLE[gi];
					pin_sync[gi] <= PIN_IDLE[gi];
				end else begin
					pin_meta[gi] <= pin_raw[gi];
					pin_sync[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	logic       cs_sync;
	logic       neg_clamp_sync;
	logic       pos_clamp_sync;
	logic       ot_sync;
	logic [3:0] peak_sync;

	assign cs_sync        = pin_sync[0];
	assign neg_clamp_sync = pin_sync[1];
	assign pos_clamp_sync = pin_sync[2];
	assign ot_sync        = pin_sync[3];
	assign peak_sync      = pin_sync[7:4];

	// ----------------------------------------------------------------
	// frame tracking
	// ----------------------------------------------------------------
	srp_pkg::srp_state_t state_reg;
	srp_pkg::srp_state_t state_next;

	// the shifter's words are quiet once select is high and the clock is
	// parked low, so the exec cycle may read them straight across
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			srp_pkg::ST_IDLE: begin
				if (!cs_sync) begin
					state_next = srp_pkg::ST_FRAME;
				end
			end
			srp_pkg::ST_FRAME: begin
				if (cs_sync) begin
					state_next = srp_pkg::ST_EXEC;
				end
			end
			default: begin
				state_next = srp_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_reg <= srp_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// command decode
	// ----------------------------------------------------------------
	logic       exec;
	logic       count_ok;
	logic [3:0] cmd;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic       cmd_valid;
	logic       exec_ok;

	// a status address is one this port holds
	function automatic logic is_status_addr(input logic [3:0] a);
		is_status_addr = (a == `SRP_VRS_KLINE_STATUS_ADDR) ||
			(a == `SRP_SYS_FAULT_STATUS_ADDR) || (a == `SRP_MODEL_REV_ADDR);
	endfunction

	assign exec     = (state_reg == srp_pkg::ST_EXEC);
	assign count_ok = (lnk.pulse_count == `SRP_FRAME_BITS);
	assign cmd      = lnk.rx_word[`SRP_CMD_MSB:`SRP_CMD_LSB];
	assign addr     = lnk.rx_word[`SRP_ADDR_MSB:`SRP_ADDR_LSB];
	assign wdata    = lnk.rx_word[7:0];

	// commands for blocks outside this port are treated as invalid
	always_comb begin
		if (cmd == srp_pkg::CMD_CHECK) begin
			cmd_valid = 1'b1;
		end else if (cmd == srp_pkg::CMD_RD_STAT || cmd == srp_pkg::CMD_WR_STAT) begin
			cmd_valid = is_status_addr(addr);
		end else if (cmd == srp_pkg::CMD_RD_CTRL || cmd == srp_pkg::CMD_WR_CTRL) begin
			cmd_valid = (addr == `SRP_SELFTEST_CTRL_ADDR);
		end else begin
			cmd_valid = 1'b0;
		end
	end

	assign exec_ok = exec && count_ok && cmd_valid;

	logic wr_stat;
	logic wr11;
	logic wr13;
	logic wr15;
	logic wr_ctrl;
	logic frame_err_set;

	assign wr_stat       = exec_ok && (cmd == srp_pkg::CMD_WR_STAT);
	assign wr11          = wr_stat && (addr == `SRP_VRS_KLINE_STATUS_ADDR);
	assign wr13          = wr_stat && (addr == `SRP_SYS_FAULT_STATUS_ADDR);
	assign wr15          = wr_stat && (addr == `SRP_MODEL_REV_ADDR);
	assign wr_ctrl       = exec_ok && (cmd == srp_pkg::CMD_WR_CTRL);
	assign frame_err_set = exec && !(count_ok && cmd_valid);

	// ----------------------------------------------------------------
	// status and control registers
	// ----------------------------------------------------------------
	logic [7:0] stat11_reg;
	logic [7:0] stat11_next;
	logic [7:0] stat13_reg;
	logic [7:0] stat13_next;
	logic [7:0] stat15_reg;
	logic       selftest_reg;

	// host write: clear-only in normal mode, free under self-test
	function automatic logic [7:0] host_write(input logic [7:0] cur,
		input logic [7:0] wd, input logic [7:0] mask, input logic st);
		if (st) begin
			host_write = wd & mask;
		end else begin
			host_write = cur & wd & mask;
		end
	endfunction

	// hardware sets are applied after the host write so a set wins a clear
	always_comb begin
		stat11_next = stat11_reg;
		if (wr11) begin
			stat11_next = host_write(stat11_reg, wdata, `SRP_VRS_KLINE_MASK, selftest_reg);
		end
		if (!selftest_reg) begin
			stat11_next[`SRP_PEAK_LSB +: 4]    = peak_sync;
			stat11_next[`SRP_KLINE_OT_BIT]  = stat11_next[`SRP_KLINE_OT_BIT] | ot_sync;
			stat11_next[`SRP_NEG_CLAMP_BIT] = stat11_next[`SRP_NEG_CLAMP_BIT] | neg_clamp_sync;
			stat11_next[`SRP_POS_CLAMP_BIT] = stat11_next[`SRP_POS_CLAMP_BIT] | pos_clamp_sync;
		end
	end

	always_comb begin
		stat13_next = stat13_reg;
		if (wr13) begin
			stat13_next = host_write(stat13_reg, wdata, `SRP_SYS_FAULT_MASK, selftest_reg);
		end
		if (!selftest_reg && frame_err_set) begin
			stat13_next[`SRP_FRAME_ERR_BIT] = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			stat11_reg <= `SRP_STATUS_RESET;
			stat13_reg <= `SRP_STATUS_RESET;
		end else begin
			stat11_reg <= stat11_next;
			stat13_reg <= stat13_next;
		end
	end

	// model and revision: only a self-test write may change it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			stat15_reg <= {MODEL_CODE, REVISION};
		end else if (wr15 && selftest_reg) begin
			stat15_reg <= wdata;
		end
	end

	// self-test write enable, written by a control write
	always_ff @(posedge core_clk) begin
		if (reset) begin
			selftest_reg <= 1'b0;
		end else if (wr_ctrl) begin
			selftest_reg <= wdata[`SRP_SELFTEST_BIT];
		end
	end

	// ----------------------------------------------------------------
	// response word
	// ----------------------------------------------------------------
	logic [7:0]  rd_data;
	logic [15:0] resp_reg;
	logic [15:0] resp_next;

	always_comb begin
		if (cmd == srp_pkg::CMD_RD_CTRL || cmd == srp_pkg::CMD_WR_CTRL) begin
			rd_data = {7'h00, selftest_reg};
		end else if (addr == `SRP_VRS_KLINE_STATUS_ADDR) begin
			rd_data = stat11_reg;
		end else if (addr == `SRP_SYS_FAULT_STATUS_ADDR) begin
			rd_data = stat13_reg;
		end else begin
			rd_data = stat15_reg;
		end
	end

	// a discarded frame leaves the pending response as it was
	always_comb begin
		resp_next = resp_reg;
		if (exec_ok) begin
			if (cmd == srp_pkg::CMD_CHECK) begin
				resp_next = {`SRP_CHECK_TOP, lnk.rx_word[11:0]};
			end else if (cmd == srp_pkg::CMD_RD_STAT || cmd == srp_pkg::CMD_RD_CTRL) begin
				resp_next = {cmd, addr, rd_data};
			end else begin
				resp_next = {cmd, addr, wdata};
			end
		end
	end

	// updated only in the exec cycle, so it is still while a frame shifts
	always_ff @(posedge core_clk) begin
		if (reset) begin
			resp_reg <= `SRP_RESP_RESET;
		end else begin
			resp_reg <= resp_next;
		end
	end

	assign lnk.resp_word = resp_reg;

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// the driver must open at the select edge itself, before any core
	// clock could see it, so enable and data follow the pin directly
	assign sdo_oe  = !chip_select_n;
	assign sdo_out = lnk.so_bit & !chip_select_n;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			selftest_write_enable <= 1'b0;
			frame_error_flag      <= 1'b0;
		end else begin
			selftest_write_enable <= selftest_reg;
			frame_error_flag      <= stat13_next[`SRP_FRAME_ERR_BIT];
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_check_echo: assert property (exec_ok && cmd == srp_pkg::CMD_CHECK |=>
		resp_reg == {4'h7, $past(lnk.rx_word[11:0])})
		else $error("check frame echo wrong");
	a_count_error: assert property (exec && !count_ok && !selftest_reg |=>
		stat13_reg[`SRP_FRAME_ERR_BIT] ##1 frame_error_flag)
		else $error("bad pulse count not flagged");
	a_count_discard: assert property (exec && !count_ok |=> $stable(resp_reg)
		and $stable(selftest_reg))
		else $error("discarded frame changed state");
	a_invalid_error: assert property (exec && count_ok && !cmd_valid && !selftest_reg
		|=> stat13_reg[`SRP_FRAME_ERR_BIT])
		else $error("invalid command not flagged");
	a_absent_zero: assert property (stat11_reg[3] == 1'b0)
		else $error("non-existent bit set");
	a_clear_only: assert property (wr11 && !selftest_reg && !ot_sync |=>
		stat11_reg[`SRP_KLINE_OT_BIT] == $past(stat11_reg[0] & wdata[0]))
		else $error("normal write set a status bit");
	a_selftest_wr: assert property (wr11 && selftest_reg |=>
		stat11_reg == ($past(wdata) & 8'hf7))
		else $error("self-test write not stored");
	a_selftest_hold: assert property (selftest_reg && !wr11 |=> $stable(stat11_reg))
		else $error("status updated during self-test");
	a_kline_set: assert property (!selftest_reg && ot_sync |=>
		stat11_reg[`SRP_KLINE_OT_BIT])
		else $error("overtemperature not captured");
	a_model_ro: assert property (!(wr15 && selftest_reg) |=> $stable(stat15_reg))
		else $error("model register changed");
	a_exec_rise: assert property (state_reg == srp_pkg::ST_FRAME && cs_sync |=>
		exec ##1 state_reg == srp_pkg::ST_IDLE)
		else $error("frame end not executed");

	c_check_frame: cover property (exec_ok && cmd == srp_pkg::CMD_CHECK);
	c_bad_count: cover property (exec && !count_ok);
	c_selftest_wr: cover property (wr11 && selftest_reg);
	c_status_read: cover property (exec_ok && cmd == srp_pkg::CMD_RD_STAT);

endmodule

`default_nettype wire

// ==== testbench/srp_host_model.sv ====
// host-side serial master model that drives the register port pins
`timescale 1ns/1ps
`default_nettype none

module srp_host_model (
	// serial pins
	output logic     sclk,
	output logic     chip_select_n,
	output logic     sdi_in,
	input wire logic sdo
);
	localparam realtime HALF = 15.0;  // 30 ns serial clock

	// ----------------------------------------------------------------
	// idle pins
	// ----------------------------------------------------------------
	// clock parked low, select parked high between frames
	initial begin
		sclk          = 1'b0;
		chip_select_n = 1'b1;
		sdi_in        = 1'b0;
	end

	// ----------------------------------------------------------------
	// transfers
	// ----------------------------------------------------------------
	// one frame of npulses clocks, msb first; reply gathered on rising edges
	task automatic xfer(input logic [15:0] word, input int npulses, output logic [15:0] reply);
		reply = 16'h0000;
		#7.3;
		chip_select_n = 1'b0;
		for (int i = 0; i < npulses; i++) begin
			sdi_in = (i < 16) ? word[15 - i] : 1'b0;
			#HALF sclk = 1'b1;
			reply = {reply[14:0], sdo};
			#HALF sclk = 1'b0;
		end
		#HALF chip_select_n = 1'b1;
		// a released data line must not keep the last bit
		sdi_in = ~sdi_in;
	endtask

	// clock and data toggling while deselected, as traffic for another slave
	task automatic idle_clocks(input int n);
		for (int i = 0; i < n; i++) begin
			sdi_in = ~sdi_in;
			#HALF sclk = 1'b1;
			#HALF sclk = 1'b0;
		end
	endtask
endmodule

`default_nettype wire

// ==== testbench/serial_register_port_bench.sv ====
// self-checking bench for the serial register port
`timescale 1ns/1ps
`default_nettype none

module serial_register_port_bench;
	localparam logic [2:0] MODEL = 3'h5;   // arbitrary value
	localparam logic [4:0] REV   = 5'h0a;  // arbitrary value

	logic        core_clk;
	logic        reset;
	logic        sclk;
	logic        chip_select_n;
	logic        sdi_in;
	logic        sdo_out;
	logic        sdo_oe;
	logic        kline_ot;
	logic        pos_clamp;
	logic        neg_clamp;
	logic [3:0]  peak;
	logic        selftest_write_enable;
	logic        frame_error_flag;
	wire         sdo_line;
	int          mismatches;
	int          checks;
	logic [15:0] bad [5] = '{16'h1000, 16'h2b00, 16'h7000, 16'h3a00, 16'h5300};

	// the pin floats whenever the port does not drive it
	assign sdo_line = sdo_oe ? sdo_out : 1'bz;

	// ----------------------------------------------------------------
	// instances
	// ----------------------------------------------------------------
	srp_port #(.MODEL_CODE(MODEL), .REVISION(REV)) u_srp_port (
		.core_clk              (core_clk),
		.reset                 (reset),
		.sclk                  (sclk),
		.chip_select_n         (chip_select_n),
		.sdi_in                (sdi_in),
		.sdo_out               (sdo_out),
		.sdo_oe                (sdo_oe),
		.kline_overtemp_in     (kline_ot),
		.vrs_pos_clamp_in      (pos_clamp),
		.vrs_neg_clamp_in      (neg_clamp),
		.vrs_peak_in           (peak),
		.selftest_write_enable (selftest_write_enable),
		.frame_error_flag      (frame_error_flag)
	);

	srp_host_model u_srp_host_model (
		.sclk          (sclk),
		.chip_select_n (chip_select_n),
		.sdi_in        (sdi_in),
		.sdo           (sdo_line)
	);

	// 200 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wait_core(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// frame, then enough idle time for the core to execute it
	task automatic frm(input logic [15:0] w, input int n, output logic [15:0] r);
		u_srp_host_model.xfer(w, n, r);
		wait_core(20);
	endtask

	// full frame whose reply answers the previous frame
	task automatic tx(input logic [15:0] w, input logic [15:0] exp);
		logic [15:0] r;
		frm(w, 16, r);
		chk(r, exp, "reply");
	endtask

	task automatic chk_flag(input logic exp);
		chk({15'h0000, frame_error_flag}, {15'h0000, exp}, "frame error flag");
	endtask

	task automatic faults(input logic ot, input logic p, input logic n, input logic [3:0] pk);
		@(negedge core_clk);
		kline_ot  = ot;
		pos_clamp = p;
		neg_clamp = n;
		peak      = pk;
		wait_core(10);
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		logic [15:0] r;
		mismatches = 0;
		checks     = 0;
		reset      = 1'b1;
		kline_ot   = 1'b0;
		pos_clamp  = 1'b0;
		neg_clamp  = 1'b0;
		peak       = 4'h0;
		repeat (12) @(negedge core_clk);
		reset = 1'b0;
		wait_core(5);
		// check word, model register read, write to a read-only register
		tx(16'h0abc, 16'h0000);
		tx(16'h3f00, 16'h7abc);
		tx(16'h4f00, {8'h3f, MODEL, REV});
		tx(16'h3f00, 16'h4f00);
		tx(16'h0fff, {8'h3f, MODEL, REV});
		tx(16'h3b00, 16'h7fff);
		tx(16'h0fff, 16'h3b00);
		chk_flag(1'b0);
		// short and long frames are dropped and flagged
		frm(16'h3d00, 15, r);
		chk_flag(1'b1);
		tx(16'h3d00, 16'h7fff);
		tx(16'h4d00, 16'h3d08);
		chk_flag(1'b0);
		frm(16'h0abc, 17, r);
		chk_flag(1'b1);
		tx(16'h4d00, 16'h4d00);
		chk_flag(1'b0);
		// invalid commands and addresses in full frames
		for (int k = 0; k < 5; k++) begin
			tx(bad[k], 16'h4d00);
			chk_flag(1'b1);
			tx(16'h4d00, 16'h4d00);
			chk_flag(1'b0);
		end
		// activity while deselected is ignored and the pin floats
		u_srp_host_model.idle_clocks(5);
		chk({15'h0000, sdo_oe}, 16'h0000, "output enable");
		// sticky faults, tracked peak, host may only clear
		faults(1'b1, 1'b1, 1'b1, 4'h9);
		faults(1'b0, 1'b0, 1'b0, 4'h9);
		tx(16'h3b00, 16'h4d00);
		tx(16'h4bff, 16'h3b97);
		tx(16'h4b00, 16'h4bff);
		tx(16'h3b00, 16'h4b00);
		tx(16'h6001, 16'h3b90);
		chk({15'h0000, selftest_write_enable}, 16'h0001, "self-test");
		// self-test: any existing bit writable, fault updates frozen
		faults(1'b1, 1'b0, 1'b0, 4'h3);
		tx(16'h4bff, 16'h6001);
		tx(16'h3b00, 16'h4bff);
		tx(16'h4b00, 16'h3bf7);
		tx(16'h3b00, 16'h4b00);
		tx(16'h4f5a, 16'h3b00);
		tx(16'h3f00, 16'h4f5a);
		tx(16'h6000, 16'h3f5a);
		chk({15'h0000, selftest_write_enable}, 16'h0000, "self-test");
		// updates resume once self-test is off
		tx(16'h3b00, 16'h6000);
		tx(16'h0000, 16'h3b31);
		tx(16'h0000, 16'h7000);
		end_sim();
	end

	// watchdog, well past the expected run of about 23 us
	initial begin
		#300000;
		mismatches++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_sim();
	end
endmodule

`default_nettype wire
